// ---- include/fd_monitor_pkg.sv ----
/*
 * Constants for the level alarm (fast detect) block: register offsets, field
 * positions, reset values and widths.
 * Assumes one clock domain at the converter output rate.
 */
package fd_monitor_pkg;
    localparam int ADDR_W = 12;
    localparam int THR_W = 13;
    localparam int DWELL_W = 16;
    localparam int MAG_W = 13;
    localparam int EVT_W = 3;
    // Printed offsets are not multiples of four: each is an index, byte address is four times it.
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h245;
    localparam logic [ADDR_W-1:0] IDX_UPPER_LOW = 12'h247;
    localparam logic [ADDR_W-1:0] IDX_UPPER_HIGH = 12'h248;
    localparam logic [ADDR_W-1:0] IDX_LOWER_LOW = 12'h249;
    localparam logic [ADDR_W-1:0] IDX_LOWER_HIGH = 12'h24A;
    localparam logic [ADDR_W-1:0] IDX_DWELL_LOW = 12'h24B;
    localparam logic [ADDR_W-1:0] IDX_DWELL_HIGH = 12'h24C;
    localparam logic [ADDR_W-1:0] IDX_SYNC_CONTROL = 12'h26F;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h280;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h281;
    localparam logic [ADDR_W-1:0] IDX_ALARM_STATE = 12'h282;
    // Fast detect control fields.
    localparam int CTL_ENABLE = 0;
    localparam int CTL_FORCE_VAL = 2;
    localparam int CTL_FORCE = 3;
    localparam logic [7:0] CTL_MASK = 8'h0D;
    // Sync control fields.
    localparam int SYNC_EN = 0;
    localparam int SYNC_NEXT = 1;
    localparam logic [7:0] SYNC_MASK = 8'h03;
    localparam logic [7:0] HIGH_MASK = 8'h1F;
    // Event bits.
    localparam int EVT_RISE = 0;
    localparam int EVT_FALL = 1;
    localparam int EVT_SYNC = 2;
    localparam logic [7:0] RESET_VAL = 8'h00;
endpackage

// ---- hw/fd_monitor.sv ----
/*
 * Level alarm block for one converter channel: upper/lower threshold compare,
 * dwell hold, force override, signal monitor sync arming, and an Avalon-MM
 * register slave with a sticky interrupt status.
 * Assumes magnitude samples arrive on i_clk qualified by i_mag_valid and that
 * i_sysref is already synchronous to i_clk.
 */
`timescale 1ns/1ns
// Behaviour
// R1: Each valid sample's magnitude is compared with the 13-bit upper threshold.
// R2: Each threshold is split into a low byte and a high byte whose bits above [4:0] read zero.
// R3: Each sample is also compared with the 13-bit lower threshold that governs release.
// R4: A 16-bit dwell counter is loaded from the dwell low and high byte registers.
// R5: The alarm pin falls only after the magnitude stays below the lower threshold for the full dwell.
// R6: In next-sync mode only the first SYSREF edge after arming resynchronises the monitor.
// R7: In next-sync mode the sync enable bit clears itself when that edge is seen.
// R8: In continuous mode every SYSREF edge resyncs and the system keeps SYSREF a multiple of the period.
// R9: With force set the pin shows the force value instead of the compare result.
// R10: The sync enable bit arms resynchronisation, which needs the SYSREF input enabled.
// R11: With fast detect disabled the pin is low and the dwell counter stays in reset; here a set force bit still drives the pin while disabled.
// R12: A sample above the upper threshold sets the pin and reloads the dwell counter.
module fd_monitor (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [fd_monitor_pkg::ADDR_W+1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_mag_valid,
    input wire logic [fd_monitor_pkg::MAG_W-1:0] i_mag,
    input wire logic i_sysref,
    input wire logic i_sysref_enable,
    output logic o_level_alarm_pin,
    output logic o_monitor_resync,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0] control_ff;
    logic [7:0] upper_low_ff;
    logic [7:0] upper_high_ff;
    logic [7:0] lower_low_ff;
    logic [7:0] lower_high_ff;
    logic [7:0] dwell_low_ff;
    logic [7:0] dwell_high_ff;
    logic [7:0] sync_ctl_ff;
    logic [fd_monitor_pkg::EVT_W-1:0] irq_status_ff;
    logic [fd_monitor_pkg::EVT_W-1:0] irq_mask_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic alarm_ff;
    logic [fd_monitor_pkg::DWELL_W-1:0] dwell_cnt_ff;
    logic sysref_prev_ff;
    logic resync_ff;

    logic [fd_monitor_pkg::ADDR_W-1:0] reg_idx;
    logic wr_en;
    logic rd_en;
    logic [fd_monitor_pkg::THR_W-1:0] upper_thr;
    logic [fd_monitor_pkg::THR_W-1:0] lower_thr;
    logic [fd_monitor_pkg::DWELL_W-1:0] dwell_load;
    logic fd_enable;
    logic sysref_edge;
    logic sync_hit;
    logic nxt_alarm;
    logic alarm_rise;
    logic alarm_fall;
    logic [fd_monitor_pkg::EVT_W-1:0] events;

    // Byte address to register index; low two bits are dropped, data sits in lane 0 except the alarm state read, which uses bits [16:0].
    function automatic logic [fd_monitor_pkg::ADDR_W-1:0] word_index(
        input logic [fd_monitor_pkg::ADDR_W+1:0] addr
    );
        word_index = addr[fd_monitor_pkg::ADDR_W+1:2];
    endfunction

    function automatic logic write_hits(input logic [fd_monitor_pkg::ADDR_W-1:0] idx,
                                        input logic [fd_monitor_pkg::ADDR_W-1:0] target);
        write_hits = (idx == target);
    endfunction

    assign reg_idx = word_index(i_avs_address);
    // A request is answered one cycle after it is first seen; waitrequest drops for that cycle.
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
    assign wr_en = i_avs_write & ack_ff & i_avs_byteenable[0];
    assign rd_en = i_avs_read & ack_ff;

    // R2: 13-bit thresholds assembled from byte pairs.
    assign upper_thr = {upper_high_ff[4:0], upper_low_ff};
    assign lower_thr = {lower_high_ff[4:0], lower_low_ff};
    // R4: dwell load from two byte registers.
    assign dwell_load = {dwell_high_ff, dwell_low_ff};
    assign fd_enable = control_ff[fd_monitor_pkg::CTL_ENABLE];

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM handshake.

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (i_avs_read | i_avs_write) & ~ack_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            control_ff <= fd_monitor_pkg::RESET_VAL;
            upper_low_ff <= fd_monitor_pkg::RESET_VAL;
            upper_high_ff <= fd_monitor_pkg::RESET_VAL;
            lower_low_ff <= fd_monitor_pkg::RESET_VAL;
            lower_high_ff <= fd_monitor_pkg::RESET_VAL;
            dwell_low_ff <= fd_monitor_pkg::RESET_VAL;
            dwell_high_ff <= fd_monitor_pkg::RESET_VAL;
            irq_mask_ff <= '0;
        end else if (wr_en) begin
            case (reg_idx)
                fd_monitor_pkg::IDX_CONTROL: control_ff <= i_avs_writedata[7:0] & fd_monitor_pkg::CTL_MASK;
                fd_monitor_pkg::IDX_UPPER_LOW: upper_low_ff <= i_avs_writedata[7:0];
                // R2: reserved high bits stay zero.
                fd_monitor_pkg::IDX_UPPER_HIGH: upper_high_ff <= i_avs_writedata[7:0] & fd_monitor_pkg::HIGH_MASK;
                fd_monitor_pkg::IDX_LOWER_LOW: lower_low_ff <= i_avs_writedata[7:0];
                fd_monitor_pkg::IDX_LOWER_HIGH: lower_high_ff <= i_avs_writedata[7:0] & fd_monitor_pkg::HIGH_MASK;
                fd_monitor_pkg::IDX_DWELL_LOW: dwell_low_ff <= i_avs_writedata[7:0];
                fd_monitor_pkg::IDX_DWELL_HIGH: dwell_high_ff <= i_avs_writedata[7:0];
                fd_monitor_pkg::IDX_IRQ_MASK: irq_mask_ff <= i_avs_writedata[fd_monitor_pkg::EVT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Signal monitor synchronisation.

    assign sysref_edge = i_sysref & ~sysref_prev_ff;
    // R10: arming needs the enable bit and an enabled SYSREF input.
    assign sync_hit = sysref_edge & i_sysref_enable & sync_ctl_ff[fd_monitor_pkg::SYNC_EN];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sysref_prev_ff <= 1'b0;
        end else begin
            sysref_prev_ff <= i_sysref;
        end
    end

    // R7: in next-sync mode the enable bit self-clears; the hardware clear wins a same-cycle write.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_ctl_ff <= fd_monitor_pkg::RESET_VAL;
        end else if (sync_hit && sync_ctl_ff[fd_monitor_pkg::SYNC_NEXT]) begin
            sync_ctl_ff[fd_monitor_pkg::SYNC_EN] <= 1'b0;
        end else if (wr_en && write_hits(reg_idx, fd_monitor_pkg::IDX_SYNC_CONTROL)) begin
            sync_ctl_ff <= i_avs_writedata[7:0] & fd_monitor_pkg::SYNC_MASK;
        end
    end

    // R6: next mode resyncs once then disarms; R8: continuous mode resyncs on every edge.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            resync_ff <= 1'b0;
        end else begin
            resync_ff <= sync_hit;
        end
    end
    assign o_monitor_resync = resync_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Threshold compare and dwell.

    always_comb begin
        nxt_alarm = alarm_ff;
        if (!fd_enable) begin
            nxt_alarm = 1'b0;
        end else if (i_mag_valid) begin
            // R1: R12: above the upper threshold sets the alarm.
            if (i_mag > upper_thr) begin
                nxt_alarm = 1'b1;
            // R3: R5: release after a full dwell below the lower threshold.
            end else if (alarm_ff && (i_mag < lower_thr) && (dwell_cnt_ff == '0)) begin
                nxt_alarm = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            alarm_ff <= 1'b0;
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    // R11: counter held clear while disabled. R12: reload on a high sample.
    // R5: any sample at or above the lower threshold restarts the wait.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dwell_cnt_ff <= '0;
        end else if (!fd_enable) begin
            dwell_cnt_ff <= '0;
        end else if (i_mag_valid) begin
            if ((i_mag > upper_thr) || (i_mag >= lower_thr)) begin
                dwell_cnt_ff <= dwell_load;
            end else if (dwell_cnt_ff != '0) begin
                dwell_cnt_ff <= dwell_cnt_ff - 1'b1;
            end
        end
    end

    // R9: force overrides the compare result and the enable; R11: pin low while disabled unless forced.
    always_comb begin
        if (control_ff[fd_monitor_pkg::CTL_FORCE]) begin
            o_level_alarm_pin = control_ff[fd_monitor_pkg::CTL_FORCE_VAL];
        end else begin
            o_level_alarm_pin = alarm_ff & fd_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts and read data.

    assign alarm_rise = nxt_alarm & ~alarm_ff;
    assign alarm_fall = ~nxt_alarm & alarm_ff & fd_enable;
    assign events = {sync_hit, alarm_fall, alarm_rise};

    // Reading the status clears the bits it returned, but an event in that same cycle is kept.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_status_ff <= '0;
        end else if (rd_en && write_hits(reg_idx, fd_monitor_pkg::IDX_IRQ_STATUS)) begin
            // Only the bits captured into the read data are cleared, because an event that arrives
            // while the read waits is newer than the reported value and would otherwise be lost.
            irq_status_ff <= (irq_status_ff & ~rdata_ff[fd_monitor_pkg::EVT_W-1:0]) | events;
        end else begin
            irq_status_ff <= irq_status_ff | events;
        end
    end
    assign o_irq = |(irq_status_ff & irq_mask_ff);

    // Unmapped indices read as zero so software can probe the map safely.
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        case (reg_idx)
            fd_monitor_pkg::IDX_CONTROL: nxt_rdata[7:0] = control_ff;
            fd_monitor_pkg::IDX_UPPER_LOW: nxt_rdata[7:0] = upper_low_ff;
            fd_monitor_pkg::IDX_UPPER_HIGH: nxt_rdata[7:0] = upper_high_ff;
            fd_monitor_pkg::IDX_LOWER_LOW: nxt_rdata[7:0] = lower_low_ff;
            fd_monitor_pkg::IDX_LOWER_HIGH: nxt_rdata[7:0] = lower_high_ff;
            fd_monitor_pkg::IDX_DWELL_LOW: nxt_rdata[7:0] = dwell_low_ff;
            fd_monitor_pkg::IDX_DWELL_HIGH: nxt_rdata[7:0] = dwell_high_ff;
            fd_monitor_pkg::IDX_SYNC_CONTROL: nxt_rdata[7:0] = sync_ctl_ff;
            fd_monitor_pkg::IDX_IRQ_STATUS: nxt_rdata[fd_monitor_pkg::EVT_W-1:0] = irq_status_ff;
            fd_monitor_pkg::IDX_IRQ_MASK: nxt_rdata[fd_monitor_pkg::EVT_W-1:0] = irq_mask_ff;
            fd_monitor_pkg::IDX_ALARM_STATE: nxt_rdata[fd_monitor_pkg::DWELL_W:0] = {dwell_cnt_ff, alarm_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    // Read data is registered when the request is first seen, so it stands at the waitrequest-low edge.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_ff <= 32'h0;
        end else if (i_avs_read && !ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign o_avs_readdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    // R12: a high sample raises the alarm on the next edge.
    chk_upper_sets_alarm: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R12
        (fd_enable && i_mag_valid && i_mag > upper_thr) |=> alarm_ff)
        else $error("alarm not set after sample above upper threshold");

    // R5: alarm cannot fall while dwell counter is nonzero.
    chk_dwell_holds_alarm: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R5
        (alarm_ff && fd_enable && dwell_cnt_ff != '0) |=> alarm_ff || !$past(fd_enable) || !fd_enable)
        else $error("alarm released before dwell expired");

    // R3: a sample at or above lower threshold keeps the alarm.
    chk_lower_keeps_alarm: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R3
        (alarm_ff && fd_enable && i_mag_valid && i_mag >= lower_thr) |=> alarm_ff)
        else $error("alarm dropped while at or above lower threshold");

    // R4: counter reloads from the dwell registers.
    chk_dwell_reload: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R4
        (fd_enable && i_mag_valid && i_mag >= lower_thr) |=> dwell_cnt_ff == $past(dwell_load))
        else $error("dwell counter not reloaded");

    // R11: disabled means pin low unless forced and counter clear.
    chk_disable_clears: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R11
        (!fd_enable && !control_ff[fd_monitor_pkg::CTL_FORCE]) |-> !o_level_alarm_pin ##1 (dwell_cnt_ff == '0))
        else $error("alarm active while fast detect disabled");

    // R9: forced value drives the pin.
    chk_force_value: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R9
        control_ff[fd_monitor_pkg::CTL_FORCE] |-> o_level_alarm_pin == control_ff[fd_monitor_pkg::CTL_FORCE_VAL])
        else $error("pin not showing forced value");

    // R7: next mode disarms after the sync edge.
    chk_next_disarms: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R7
        (sync_hit && sync_ctl_ff[fd_monitor_pkg::SYNC_NEXT]) |=> !sync_ctl_ff[fd_monitor_pkg::SYNC_EN])
        else $error("sync enable not cleared in next mode");

    // R6: a resync pulse follows only an armed, enabled SYSREF edge.
    chk_resync_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R6
        o_monitor_resync |-> $past(sysref_edge && i_sysref_enable && sync_ctl_ff[fd_monitor_pkg::SYNC_EN]))
        else $error("resync without armed SYSREF edge");

    // R2: reserved high bits read zero.
    chk_high_reserved: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R2
        (upper_high_ff[7:5] == 3'h0) && (lower_high_ff[7:5] == 3'h0))
        else $error("reserved threshold bits set");

    // R10: without SYSREF enabled no resync occurs.
    chk_sysref_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R10
        !i_sysref_enable |=> !o_monitor_resync)
        else $error("resync with SYSREF input disabled");

    // R12: status bits are sticky, so every event shows in the status on the next edge.
    chk_event_sticky: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R12
        (events != '0) |=> ((irq_status_ff & $past(events)) == $past(events)))
        else $error("event lost from interrupt status");

    // R12: a status read clears the reported bits when no new event arrives with it.
    chk_status_read_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R12
        (rd_en && reg_idx == fd_monitor_pkg::IDX_IRQ_STATUS && events == '0) |=>
            ((irq_status_ff & $past(rdata_ff[fd_monitor_pkg::EVT_W-1:0])) == '0))
        else $error("status bits not cleared by read");

endmodule // fd_monitor

// ---- verification/fd_gain_model.sv ----
/*
 * Behavioural model of the external gain control that watches the level alarm pin.
 * Assumes the pin is sampled on the converter output clock, with no extra synchroniser.
 */
`timescale 1ns/1ns
module fd_gain_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_level_alarm_pin,
    output logic [7:0] o_backoff_steps
);
    logic pin_prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Each new alarm backs the gain off by one step, as a simple loop would.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_prev_ff <= 1'b0;
            o_backoff_steps <= 8'h00;
        end else begin
            pin_prev_ff <= i_level_alarm_pin;
            if (i_level_alarm_pin && !pin_prev_ff) begin
                o_backoff_steps <= o_backoff_steps + 8'h01;
            end
        end
    end
endmodule // fd_gain_model

// ---- verification/test_fd_monitor.sv ----
/*
 * Self-checking bench for the level alarm block: registers, thresholds, dwell, force, sync and interrupt.
 * Assumes one 250 MHz clock and the one-wait-cycle Avalon slave of the design.
 */
`timescale 1ns/1ns
module test_fd_monitor;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [13:0] i_avs_address = 14'h0000;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0] i_avs_byteenable = 4'h1;
    logic i_mag_valid = 1'b0;
    logic [12:0] i_mag = 13'h0000;
    logic i_sysref = 1'b0;
    logic i_sysref_enable = 1'b0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic o_level_alarm_pin;
    logic o_monitor_resync;
    logic o_irq;
    logic [7:0] backoff_steps;
    logic [31:0] q;
    int miscompares = 0;
    int num_checks = 0;
    int resync_seen = 0;

    always #2 i_clk = ~i_clk;

    fd_monitor dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_mag_valid(i_mag_valid), .i_mag(i_mag),
        .i_sysref(i_sysref), .i_sysref_enable(i_sysref_enable), .o_level_alarm_pin(o_level_alarm_pin),
        .o_monitor_resync(o_monitor_resync), .o_irq(o_irq));

    fd_gain_model gain_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_level_alarm_pin(o_level_alarm_pin),
        .o_backoff_steps(backoff_steps));

    always @(posedge i_clk) begin
        if (o_monitor_resync === 1'b1) begin
            resync_seen <= resync_seen + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The request is held until waitrequest is sampled low; data is taken at that edge.
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] be);
        @(posedge i_clk);
        i_avs_address <= {idx, 2'b00};
        i_avs_writedata <= {24'h000000, d};
        i_avs_byteenable <= be;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        // Let the write or read-clear settle before the caller looks at any output.
        @(negedge i_clk);
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask

    task automatic rd(input string name, input logic [11:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'h1);
        check(name, q, {24'h000000, exp});
    endtask

    task automatic sample(input logic [12:0] m);
        @(posedge i_clk);
        i_mag <= m;
        i_mag_valid <= 1'b1;
        @(posedge i_clk);
        i_mag_valid <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic pulse_sysref();
        @(posedge i_clk);
        i_sysref <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_sysref <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_registers();
        logic [11:0] idx [8] = '{fd_monitor_pkg::IDX_CONTROL, fd_monitor_pkg::IDX_UPPER_LOW,
            fd_monitor_pkg::IDX_UPPER_HIGH, fd_monitor_pkg::IDX_LOWER_LOW, fd_monitor_pkg::IDX_LOWER_HIGH,
            fd_monitor_pkg::IDX_DWELL_LOW, fd_monitor_pkg::IDX_DWELL_HIGH, fd_monitor_pkg::IDX_SYNC_CONTROL};
        for (int i = 0; i < 8; i++) begin
            rd("reset value", idx[i], fd_monitor_pkg::RESET_VAL);
        end
        rd("unmapped", 12'h300, 8'h00);
        wr(fd_monitor_pkg::IDX_UPPER_HIGH, 8'hFF);
        rd("upper high", fd_monitor_pkg::IDX_UPPER_HIGH, 8'h1F);
        wr(fd_monitor_pkg::IDX_LOWER_HIGH, 8'hFF);
        rd("lower high", fd_monitor_pkg::IDX_LOWER_HIGH, 8'h1F);
        bus(1'b1, fd_monitor_pkg::IDX_DWELL_LOW, 8'h55, 4'h0);
        rd("dwell no strobe", fd_monitor_pkg::IDX_DWELL_LOW, 8'h00);
    endtask

    // Dwell of 0x0102 needs its high byte: D low samples keep the pin, the next one drops it.
    task automatic t_threshold();
        wr(fd_monitor_pkg::IDX_UPPER_LOW, 8'h34);
        wr(fd_monitor_pkg::IDX_UPPER_HIGH, 8'h12);
        wr(fd_monitor_pkg::IDX_LOWER_LOW, 8'h00);
        wr(fd_monitor_pkg::IDX_LOWER_HIGH, 8'h01);
        wr(fd_monitor_pkg::IDX_DWELL_LOW, 8'h02);
        wr(fd_monitor_pkg::IDX_DWELL_HIGH, 8'h01);
        wr(fd_monitor_pkg::IDX_IRQ_MASK, 8'h01);
        wr(fd_monitor_pkg::IDX_CONTROL, 8'h01);
        sample(13'h1234);
        check("pin at upper", o_level_alarm_pin, 1'b0);
        sample(13'h1235);
        check("pin above upper", o_level_alarm_pin, 1'b1);
        check("irq rise", o_irq, 1'b1);
        rd("status rise", fd_monitor_pkg::IDX_IRQ_STATUS, 8'h01);
        check("irq cleared", o_irq, 1'b0);
        bus(1'b0, fd_monitor_pkg::IDX_ALARM_STATE, 8'h00, 4'h1);
        check("alarm state", q, {15'h0000, 16'h0102, 1'h1});
        repeat (16'h0102) sample(13'h00FF);
        check("pin in dwell", o_level_alarm_pin, 1'b1);
        sample(13'h0100);
        repeat (16'h0102) sample(13'h00FF);
        check("pin restarted", o_level_alarm_pin, 1'b1);
        sample(13'h00FF);
        check("pin released", o_level_alarm_pin, 1'b0);
        rd("status fall", fd_monitor_pkg::IDX_IRQ_STATUS, 8'h02);
        check("gain steps", backoff_steps, 8'h01);
    endtask

    task automatic t_enable_force();
        sample(13'h1FFF);
        wr(fd_monitor_pkg::IDX_CONTROL, 8'h00);
        check("pin disabled", o_level_alarm_pin, 1'b0);
        sample(13'h1FFF);
        check("pin disabled sample", o_level_alarm_pin, 1'b0);
        wr(fd_monitor_pkg::IDX_CONTROL, 8'h0D);
        check("force one", o_level_alarm_pin, 1'b1);
        sample(13'h1FFF);
        wr(fd_monitor_pkg::IDX_CONTROL, 8'h09);
        check("force zero", o_level_alarm_pin, 1'b0);
        wr(fd_monitor_pkg::IDX_CONTROL, 8'h01);
        check("force off", o_level_alarm_pin, 1'b1);
        rd("control", fd_monitor_pkg::IDX_CONTROL, 8'h01);
    endtask

    task automatic t_sync();
        rd("status flush", fd_monitor_pkg::IDX_IRQ_STATUS, 8'h01);
        wr(fd_monitor_pkg::IDX_IRQ_MASK, 8'h04);
        @(posedge i_clk);
        i_sysref_enable <= 1'b1;
        wr(fd_monitor_pkg::IDX_SYNC_CONTROL, 8'h03);
        pulse_sysref();
        check("irq resync", o_irq, 1'b1);
        pulse_sysref();
        check("next mode count", resync_seen, 1);
        rd("sync self clear", fd_monitor_pkg::IDX_SYNC_CONTROL, 8'h02);
        rd("status resync", fd_monitor_pkg::IDX_IRQ_STATUS, 8'h04);
        wr(fd_monitor_pkg::IDX_SYNC_CONTROL, 8'h01);
        pulse_sysref();
        pulse_sysref();
        check("continuous count", resync_seen, 3);
        rd("sync kept", fd_monitor_pkg::IDX_SYNC_CONTROL, 8'h01);
        @(posedge i_clk);
        i_sysref_enable <= 1'b0;
        pulse_sysref();
        check("sysref disabled", resync_seen, 3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_registers();
        t_threshold();
        t_enable_force();
        t_sync();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        print_verdict();
    end
endmodule // test_fd_monitor
